// ==== verilog/imsa_top.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: buffer write during receive ignored, collision flagged
// RULE2: ack enable pulls clock low, drives ack bit
// RULE3: software picks ack or nack beforehand
// RULE4: ack: period, release, period, clock low, idle
// RULE5: buffer write during ack ignored, collision flagged
// RULE6: stop drives data low, then counts period
// RULE7: stop releases clock, data one period later
// RULE8: stop seen sets flag, later interrupt
// RULE9: buffer write during stop ignored, collision flagged
// RULE10: counter holds until released clock reads high
// RULE11: port keeps working asleep, wakes on completion
// RULE12: reset disables port, aborts transfer
// RULE13: expected one read zero means collision
// RULE14: transmit collision halts, clears full, releases lines
// RULE15: condition collision aborts, clears enable bits
// RULE16: after collision, observed stop raises interrupt
// RULE17: next write restarts from first bit
// RULE18: software takes bus only when free
// RULE19: line low at start aborts with collision
// RULE20: start counts; low clock is collision
// RULE21: data low in start count asserts early
// RULE22: hold data low one period, then clock
// RULE23: period is reload count on instruction tick
module imsa_top
    import imsa_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic srst, // synchronous reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic sclIn, // clock line level
    output logic sclOut, // clock line drive value, always low
    output logic sclOen, // low while pulling clock line low
    input wire logic sdaIn, // data line level
    output logic sdaOut, // data line drive value, always low
    output logic sdaOen, // low while pulling data line low
    output logic wakeReq // wake request to the processor
);
    imsa_state_t state;
    logic [1:0] sclSync, sdaSync;
    logic sclS, sdaS, sdaPrev;
    logic [7:0] divCnt;
    logic tick;
    logic [RELOAD_W-1:0] brgCnt, rateReloadValue;
    logic expire, countState;
    logic [7:0] shiftRegister, xferBuffer;
    logic [3:0] bitCnt;
    logic startEn, stopEn, rcvEn, ackSeqEnable, ackDataBit, portEn, intEn;
    logic bufferFullFlag, ackStat, startDet, stopDet, writeCollisionFlag;
    logic portIntFlag, busCollisionFlag, rxOvf, lostArb;
    logic apbSetup, wrEv, rdEv, wrBuf, wrCtl, wrStat, busy, bufAccept, wcolEv;
    logic collide, startDone, ackDone, stopDone, rxDone, txEnd, txAckDone;
    logic stopSeen, busStart, busStop, txState;
    logic [31:0] rdValue;
    logic rdMapped;

    assign sclS = sclSync[1];
    assign sdaS = sdaSync[1];

    // two-stage synchronisers; only the second stage is read
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            sdaPrev <= 1'b1;
        end
        else
        begin
            sclSync <= {sclSync[0], sclIn};
            sdaSync <= {sdaSync[0], sdaIn};
            sdaPrev <= sdaSync[1];
        end
    end

    // instruction-rate tick that paces the bit-rate counter [RULE23]
    always_ff @(posedge ref_clk)
    begin
        if (srst || divCnt == 8'(TICK_DIV - 1))
            divCnt <= 8'h00;
        else
            divCnt <= divCnt + 8'h01;
    end
    assign tick = (divCnt == 8'(TICK_DIV - 1));

    // bus start/stop watcher, active whatever the sequencer does
    assign busStart = sclS && sdaPrev && !sdaS;
    assign busStop = sclS && !sdaPrev && sdaS;

    // apb decode; ready and data registered from the setup phase, no wait state
    assign apbSetup = psel && !penable;
    assign wrEv = psel && penable && pready && pwrite;
    assign rdEv = psel && penable && pready && !pwrite;
    assign wrBuf = wrEv && paddr == ADDR_BUF;
    assign wrCtl = wrEv && paddr == ADDR_CTRL;
    assign wrStat = wrEv && paddr == ADDR_STAT;
    assign busy = state != S_IDLE || startEn || stopEn || rcvEn || ackSeqEnable;
    assign bufAccept = wrBuf && !busy && portEn;
    assign wcolEv = wrBuf && busy; // [RULE1] [RULE5] [RULE9]
    assign txState = state == S_TX_LOW || state == S_TX_REL || state == S_TX_HIGH;

    always_comb
    begin
        rdValue = 32'h0;
        rdMapped = 1'b1;
        case (paddr)
            ADDR_CTRL:
            begin
                rdValue[CTL_START] = startEn;
                rdValue[CTL_STOP] = stopEn;
                rdValue[CTL_RCV] = rcvEn;
                rdValue[CTL_ACKEN] = ackSeqEnable;
                rdValue[CTL_ACKDT] = ackDataBit;
            end
            ADDR_STAT:
            begin
                rdValue[ST_BF] = bufferFullFlag;
                rdValue[ST_ACKSTAT] = ackStat;
                rdValue[ST_START] = startDet;
                rdValue[ST_STOP] = stopDet;
                rdValue[ST_WRITE_COLLISION_FLAG] = writeCollisionFlag;
                rdValue[ST_PINT] = portIntFlag;
                rdValue[ST_BCL] = busCollisionFlag;
                rdValue[ST_OVF] = rxOvf;
            end
            ADDR_BUF: rdValue[7:0] = xferBuffer;
            ADDR_RELOAD: rdValue[RELOAD_W-1:0] = rateReloadValue;
            ADDR_CFG:
            begin
                rdValue[CFG_EN] = portEn;
                rdValue[CFG_IE] = intEn;
            end
            default: rdMapped = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= apbSetup;
            pslverr <= apbSetup && !rdMapped;
            prdata <= apbSetup ? rdValue : 32'h0;
        end
    end

    // sequence events; the counter only expires in counting states
    assign countState = state inside {S_START_CNT, S_START_HOLD, S_TX_LOW, S_TX_HIGH, S_RX_LOW, S_RX_HIGH,
                                      S_ACK_LOW, S_ACK_HIGH, S_STOP_CNT, S_STOP_HIGH, S_STOP_DONE};
    assign expire = countState && tick && brgCnt == '0;
    always_comb
    begin
        collide = 1'b0;
        unique case (state)
            S_START_CHK: collide = !sdaS || !sclS; // [RULE19]
            S_START_CNT: collide = sdaS && !sclS; // [RULE20]
            S_TX_HIGH: collide = bitCnt != ACK_BIT && sdaOen && !sdaS; // [RULE13]
            S_ACK_HIGH: collide = sdaOen && !sdaS; // [RULE13]
            S_STOP_HIGH: collide = !sclS; // [RULE13]
            default: collide = 1'b0;
        endcase
    end
    assign startDone = state == S_START_HOLD && expire;
    assign ackDone = state == S_ACK_HIGH && expire && !collide;
    assign stopSeen = state == S_STOP_SDA && sdaS && sclS;
    assign stopDone = state == S_STOP_DONE && expire;
    assign rxDone = state == S_RX_HIGH && expire && bitCnt == LAST_BIT;
    assign txEnd = state == S_TX_HIGH && expire && !collide && bitCnt == LAST_BIT;
    assign txAckDone = state == S_TX_HIGH && expire && bitCnt == ACK_BIT;

    // sequencer: line drives, bit-rate counter, shifting
    always_ff @(posedge ref_clk)
    begin
        if (srst || !portEn)
        begin
            state <= S_IDLE; // [RULE12]
            sclOen <= 1'b1;
            sdaOen <= 1'b1;
            brgCnt <= '0;
            bitCnt <= 4'h0;
            shiftRegister <= 8'h00;
            ackStat <= 1'b0;
        end
        else
        begin
            if (countState && tick && brgCnt != '0)
                brgCnt <= brgCnt - 1'b1; // [RULE23]
            unique case (state)
                S_IDLE:
                begin
                    if (startEn)
                        state <= S_START_CHK;
                    else if (stopEn)
                    begin
                        sdaOen <= 1'b0; // [RULE6]
                        state <= S_STOP_LOW;
                    end
                    else if (rcvEn)
                    begin
                        sdaOen <= 1'b1;
                        sclOen <= 1'b0;
                        brgCnt <= rateReloadValue;
                        bitCnt <= 4'h0;
                        state <= S_RX_LOW;
                    end
                    else if (ackSeqEnable)
                    begin
                        sclOen <= 1'b0; // [RULE2]
                        sdaOen <= ackDataBit; // [RULE2] [RULE3]
                        brgCnt <= rateReloadValue;
                        state <= S_ACK_LOW;
                    end
                    else if (bufAccept)
                    begin
                        shiftRegister <= pwdata[7:0]; // always from the first bit [RULE17]
                        sdaOen <= pwdata[7];
                        sclOen <= 1'b0;
                        bitCnt <= 4'h0;
                        brgCnt <= rateReloadValue;
                        state <= S_TX_LOW;
                    end
                end
                S_START_CHK:
                begin
                    brgCnt <= rateReloadValue; // [RULE20]
                    state <= S_START_CNT;
                end
                S_START_CNT:
                begin
                    if (!sdaS || expire)
                    begin
                        sdaOen <= 1'b0; // early when another master leads [RULE21] [RULE22]
                        brgCnt <= rateReloadValue;
                        state <= S_START_HOLD;
                    end
                end
                S_START_HOLD:
                begin
                    if (expire)
                    begin
                        sclOen <= 1'b0; // low clock ignored while holding [RULE22]
                        state <= S_IDLE;
                    end
                end
                S_TX_LOW, S_RX_LOW, S_ACK_LOW:
                begin
                    if (expire)
                    begin
                        sclOen <= 1'b1;
                        state <= state == S_TX_LOW ? S_TX_REL : (state == S_RX_LOW ? S_RX_REL : S_ACK_REL);
                    end
                end
                S_TX_REL, S_RX_REL, S_ACK_REL, S_STOP_REL:
                begin
                    // a slave may stretch the clock; high time starts on the real edge
                    if (sclS)
                    begin
                        brgCnt <= rateReloadValue; // [RULE10]
                        unique case (state)
                            S_TX_REL: state <= S_TX_HIGH;
                            S_RX_REL: state <= S_RX_HIGH;
                            S_ACK_REL: state <= S_ACK_HIGH;
                            default: state <= S_STOP_HIGH;
                        endcase
                    end
                end
                S_TX_HIGH:
                begin
                    if (expire)
                    begin
                        sclOen <= 1'b0;
                        brgCnt <= rateReloadValue;
                        if (bitCnt == ACK_BIT)
                        begin
                            ackStat <= sdaS;
                            state <= S_IDLE; // counter suspended, clock held low
                        end
                        else
                        begin
                            bitCnt <= bitCnt + 4'h1;
                            shiftRegister <= {shiftRegister[6:0], 1'b0};
                            sdaOen <= bitCnt == LAST_BIT ? 1'b1 : shiftRegister[6];
                            state <= S_TX_LOW;
                        end
                    end
                end
                S_RX_HIGH:
                begin
                    if (expire)
                    begin
                        shiftRegister <= {shiftRegister[6:0], sdaS};
                        sclOen <= 1'b0;
                        bitCnt <= bitCnt + 4'h1;
                        brgCnt <= rateReloadValue;
                        state <= bitCnt == LAST_BIT ? S_IDLE : S_RX_LOW;
                    end
                end
                S_ACK_HIGH:
                begin
                    if (expire)
                    begin
                        sclOen <= 1'b0; // [RULE4]
                        state <= S_IDLE;
                    end
                end
                S_STOP_LOW:
                begin
                    if (!sdaS)
                    begin
                        brgCnt <= rateReloadValue; // [RULE6]
                        state <= S_STOP_CNT;
                    end
                end
                S_STOP_CNT:
                begin
                    if (expire)
                    begin
                        sclOen <= 1'b1; // [RULE7]
                        state <= S_STOP_REL;
                    end
                end
                S_STOP_HIGH:
                begin
                    if (expire)
                    begin
                        sdaOen <= 1'b1; // one period after the clock went high [RULE7]
                        state <= S_STOP_SDA;
                    end
                end
                S_STOP_SDA:
                begin
                    if (stopSeen)
                    begin
                        brgCnt <= rateReloadValue;
                        state <= S_STOP_DONE;
                    end
                end
                S_STOP_DONE:
                begin
                    if (expire)
                        state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            if (collide)
            begin
                sclOen <= 1'b1; // [RULE14] [RULE15]
                sdaOen <= 1'b1;
                state <= S_IDLE; // [RULE13] [RULE19]
            end
        end
    end

    // control bits; only one condition may be queued at a time
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            {startEn, stopEn, rcvEn, ackSeqEnable, ackDataBit} <= 5'h00;
            portEn <= 1'b0;
            intEn <= 1'b0;
            rateReloadValue <= RELOAD_RST;
        end
        else
        begin
            if (wrCtl)
                ackDataBit <= pwdata[CTL_ACKDT];
            if (wrCtl && !busy && portEn)
            begin
                startEn <= pwdata[CTL_START];
                stopEn <= pwdata[CTL_STOP] && !pwdata[CTL_START];
                rcvEn <= pwdata[CTL_RCV] && !pwdata[CTL_START] && !pwdata[CTL_STOP];
                ackSeqEnable <= pwdata[CTL_ACKEN] && !pwdata[CTL_START] && !pwdata[CTL_STOP] && !pwdata[CTL_RCV];
            end
            if (startDone)
                startEn <= 1'b0;
            if (ackDone)
                ackSeqEnable <= 1'b0; // [RULE4]
            if (stopDone)
                stopEn <= 1'b0; // [RULE8]
            if (rxDone)
                rcvEn <= 1'b0;
            if (collide || !portEn)
            begin
                startEn <= 1'b0; // [RULE15]
                stopEn <= 1'b0;
                ackSeqEnable <= 1'b0;
                rcvEn <= 1'b0;
            end
            if (wrEv && paddr == ADDR_CFG)
            begin
                portEn <= pwdata[CFG_EN];
                intEn <= pwdata[CFG_IE];
            end
            if (wrEv && paddr == ADDR_RELOAD)
                rateReloadValue <= pwdata[RELOAD_W-1:0];
        end
    end

    // status flags and transfer buffer; a set beats a same-cycle clear
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            {bufferFullFlag, startDet, stopDet, writeCollisionFlag} <= 4'h0;
            {portIntFlag, busCollisionFlag, rxOvf, lostArb} <= 4'h0;
            xferBuffer <= 8'h00;
            wakeReq <= 1'b0;
        end
        else
        begin
            if (wrStat && pwdata[ST_WRITE_COLLISION_FLAG])
                writeCollisionFlag <= 1'b0;
            if (wcolEv)
                writeCollisionFlag <= 1'b1; // [RULE1] [RULE5] [RULE9]
            if (bufAccept)
                xferBuffer <= pwdata[7:0];
            else if (rxDone)
                xferBuffer <= {shiftRegister[6:0], sdaS};
            if ((rdEv && paddr == ADDR_BUF) || txEnd || (collide && txState))
                bufferFullFlag <= 1'b0; // [RULE14]
            if (bufAccept || rxDone)
                bufferFullFlag <= 1'b1;
            if (wrStat && pwdata[ST_OVF])
                rxOvf <= 1'b0;
            if (rxDone && bufferFullFlag)
                rxOvf <= 1'b1;
            if (busStart)
                {startDet, stopDet} <= 2'h2;
            if (busStop || stopSeen)
                {startDet, stopDet} <= 2'h1; // [RULE8]
            if (busStop)
                lostArb <= 1'b0;
            if (collide)
                lostArb <= 1'b1;
            if (wrStat && pwdata[ST_BCL])
                busCollisionFlag <= 1'b0;
            if (collide)
                busCollisionFlag <= 1'b1; // [RULE13]
            if (wrStat && pwdata[ST_PINT])
                portIntFlag <= 1'b0;
            if (startDone || ackDone || stopDone || rxDone || txAckDone || (busStop && lostArb))
                portIntFlag <= 1'b1; // [RULE8] [RULE16]
            wakeReq <= portIntFlag && intEn; // works without the processor clock [RULE11]
        end
    end

    // pins only ever pull low; the enables carry the level
    always_ff @(posedge ref_clk)
    begin
        sclOut <= 1'b0;
        sdaOut <= 1'b0;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || !portEn);

    sequence sAckEnd;
        state == S_ACK_HIGH && expire && !collide;
    endsequence
    sequence sReleasedIdle;
        state == S_IDLE && sclOen && sdaOen;
    endsequence

    AST_RX_WRITE_COLLISION_FLAG: assert property (wrBuf && state inside {S_RX_LOW, S_RX_REL, S_RX_HIGH} && !rxDone // [RULE1]
        |=> writeCollisionFlag && $stable(xferBuffer)) else $error("receive write not refused");
    AST_ACK_DRIVE: assert property (state == S_IDLE && !startEn && !stopEn && !rcvEn && ackSeqEnable // [RULE2]
        |=> !sclOen && sdaOen == ackDataBit && state == S_ACK_LOW) else $error("ack not driven");
    AST_ACK_END: assert property (sAckEnd |=> state == S_IDLE && !sclOen && !ackSeqEnable) // [RULE4]
        else $error("ack end wrong");
    AST_ACK_WRITE_COLLISION_FLAG: assert property (wrBuf && state inside {S_ACK_LOW, S_ACK_REL, S_ACK_HIGH} // [RULE5]
        |=> writeCollisionFlag && $stable(xferBuffer)) else $error("ack write not refused");
    AST_STOP_LOW: assert property (state == S_STOP_LOW && !sdaS // [RULE6]
        |=> state == S_STOP_CNT && brgCnt == rateReloadValue && !sdaOen) else $error("stop count not loaded");
    AST_STOP_REL: assert property (state == S_STOP_CNT && expire // [RULE7]
        |=> sclOen && !sdaOen && state == S_STOP_REL) else $error("stop clock release wrong");
    AST_STOP_END: assert property (stopSeen |=> stopDet && stopEn && state == S_STOP_DONE) // [RULE8]
        else $error("stop detect missed");
    AST_STOP_FLAG: assert property (stopDone |=> !stopEn && portIntFlag) // [RULE8]
        else $error("stop completion wrong");
    AST_STOP_WRITE_COLLISION_FLAG: assert property (wrBuf && state inside {S_STOP_LOW, S_STOP_CNT, S_STOP_SDA} // [RULE9]
        |=> writeCollisionFlag && $stable(xferBuffer)) else $error("stop write not refused");
    AST_STRETCH: assert property (state inside {S_TX_REL, S_RX_REL, S_ACK_REL, S_STOP_REL} && !sclS // [RULE10]
        |=> $stable(brgCnt) && $stable(state)) else $error("counter ran during stretch");
    AST_TX_COLL: assert property (state == S_TX_HIGH && bitCnt != ACK_BIT && sdaOen && !sdaS // [RULE14]
        |=> sReleasedIdle and busCollisionFlag && !bufferFullFlag) else $error("transmit collision wrong");
    AST_START_ABORT: assert property (state == S_START_CHK && (!sdaS || !sclS) // [RULE19]
        |=> sReleasedIdle and busCollisionFlag && !startEn) else $error("start abort wrong");
    AST_START_EARLY: assert property (state == S_START_CNT && !sdaS && sclS // [RULE21]
        |=> state == S_START_HOLD && !sdaOen && $stable(busCollisionFlag)) else $error("early start wrong");
    AST_WAKE: assert property (portIntFlag && intEn |=> wakeReq) // [RULE11]
        else $error("wake request missing");
endmodule

// ==== verilog/imsa_pkg.sv ====
package imsa_pkg;
    // register byte addresses on the APB side
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_BUF = 8'h08;
    localparam logic [7:0] ADDR_RELOAD = 8'h0c;
    localparam logic [7:0] ADDR_CFG = 8'h10;
    // control_reg_2 bit positions
    localparam int CTL_START = 0;
    localparam int CTL_STOP = 2;
    localparam int CTL_RCV = 3;
    localparam int CTL_ACKEN = 4;
    localparam int CTL_ACKDT = 5;
    // status_reg bit positions
    localparam int ST_BF = 0;
    localparam int ST_ACKSTAT = 1;
    localparam int ST_START = 3;
    localparam int ST_STOP = 4;
    localparam int ST_WRITE_COLLISION_FLAG = 5;
    localparam int ST_PINT = 6;
    localparam int ST_BCL = 7;
    localparam int ST_OVF = 8;
    // configuration bit positions
    localparam int CFG_EN = 0;
    localparam int CFG_IE = 1;
    // reload field and its reset value
    localparam int RELOAD_W = 7;
    localparam logic [6:0] RELOAD_RST = 7'h09;
    // instruction-rate tick derived from the system clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int INSTR_PERIOD_NS = 32;
    localparam int TICK_DIV = INSTR_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [4:0] {
        S_IDLE, S_START_CHK, S_START_CNT, S_START_HOLD,
        S_TX_LOW, S_TX_REL, S_TX_HIGH,
        S_RX_LOW, S_RX_REL, S_RX_HIGH,
        S_ACK_LOW, S_ACK_REL, S_ACK_HIGH,
        S_STOP_LOW, S_STOP_CNT, S_STOP_REL, S_STOP_HIGH, S_STOP_SDA, S_STOP_DONE
    } imsa_state_t;
endpackage

// ==== verification/imsa_bus_peer.sv ====
`timescale 1ns/10ps
// far-side slave: stretches the clock, pulls data low on request
module imsa_bus_peer (
    input wire logic ref_clk, // system clock
    input wire logic srst, // reset
    input wire logic sclOen, // device clock enable, low pulls
    input wire logic [7:0] stretch, // cycles held low after release
    input wire logic holdSda, // bench asks for data held low
    output logic peerSclOen, // low while peer pulls clock
    output logic peerSdaOen // low while peer pulls data
);
    logic [7:0] cnt;
    // a slow slave keeps the clock low after the master lets go
    always_ff @(posedge ref_clk)
    begin
        if (srst || !sclOen)
            cnt <= srst ? 8'h00 : stretch;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end
    assign peerSclOen = (cnt == 8'h00);
    assign peerSdaOen = !holdSda;
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb
    import imsa_pkg::*;
;
    logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, errSeen;
    logic sclOen, sdaOen, wakeReq, pScl, pSda, holdSda, ack;
    logic [7:0] paddr, stretch;
    logic [31:0] pwdata, prdata, rd, seed;
    int errCount, checksDone;
    // open-drain lines with pull-ups
    wire sclLine = sclOen & pScl;
    wire sdaLine = sdaOen & pSda;
    imsa_top imsa_top_i (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclLine),
        .sclOut(), .sclOen(sclOen), .sdaIn(sdaLine), .sdaOut(), .sdaOen(sdaOen), .wakeReq(wakeReq));
    imsa_bus_peer imsa_bus_peer_i (.ref_clk(ref_clk), .srst(srst), .sclOen(sclOen), .stretch(stretch),
        .holdSda(holdSda), .peerSclOen(pScl), .peerSdaOen(pSda));
    // one step of the xorshift generator behind every random stimulus value
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finalReport;
        $display("mismatches %0d comparisons %0d", errCount, checksDone);
        if (errCount == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer; data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        errSeen = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20)
        begin
            errCount++;
            finalReport();
        end
    endtask
    // poll a bit under a bounded count
    task automatic waitbit(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        while (rd[b] !== v && n < 300);
        if (n >= 300)
        begin
            errCount++;
            finalReport();
        end
    endtask
    // clock and watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        errCount++;
        finalReport();
    end
    // main sequence; expected status given as literal masks and values
    initial
    begin
        {srst, psel, penable, pwrite, paddr, pwdata, holdSda, stretch} = {1'b1, 52'h0};
        seed = xorshift(32'h1d);
        ack = seed[8];
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        apb(1'b0, ADDR_RELOAD, 32'h0);
        chk(rd, 32'h09);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(errSeen), 32'h1);
        apb(1'b1, ADDR_CFG, 32'h3);
        apb(1'b1, ADDR_RELOAD, 32'(seed % 3 + 1));
        stretch <= 8'h10;
        apb(1'b1, ADDR_CTRL, (32'h1 << CTL_ACKEN) | (32'(ack) << CTL_ACKDT));
        repeat (3) @(posedge ref_clk);
        chk(32'({sclOen, sdaOen}), 32'(ack));
        apb(1'b1, ADDR_BUF, 32'h5a);
        waitbit(ADDR_CTRL, CTL_ACKEN, 1'b0);
        chk(32'(sclOen), 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd & 32'he0, 32'h60);
        apb(1'b1, ADDR_STAT, 32'h1e0);
        // receive from an idle-high data line; the buffer write meanwhile must bounce
        apb(1'b1, ADDR_CTRL, 32'h1 << CTL_RCV);
        apb(1'b1, ADDR_BUF, 32'h3c);
        waitbit(ADDR_CTRL, CTL_RCV, 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd & 32'h1e1, 32'h61);
        apb(1'b0, ADDR_BUF, 32'h0);
        chk(rd, 32'hff);
        apb(1'b1, ADDR_STAT, 32'h1e0);
        apb(1'b1, ADDR_CTRL, 32'h1 << CTL_STOP);
        apb(1'b1, ADDR_BUF, 32'ha5);
        chk(32'(sdaOen), 32'h0);
        waitbit(ADDR_CTRL, CTL_STOP, 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd & 32'hf0, 32'h70);
        chk(32'({sclOen, sdaOen, wakeReq}), 32'h7);
        apb(1'b1, ADDR_STAT, 32'h1e0);
        holdSda <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h1 << CTL_START);
        waitbit(ADDR_STAT, ST_BCL, 1'b1);
        chk(32'({sclOen, sdaOen}), 32'h3);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(32'(rd[CTL_START]), 32'h0);
        // a data one met by a held-low line: transmit collision empties the buffer
        apb(1'b1, ADDR_STAT, 32'h1e0);
        apb(1'b1, ADDR_BUF, 32'hff);
        waitbit(ADDR_STAT, ST_BCL, 1'b1);
        chk(rd & 32'h81, 32'h80);
        chk(32'({sclOen, sdaOen}), 32'h3);
        holdSda <= 1'b0;
        waitbit(ADDR_STAT, ST_PINT, 1'b1);
        chk(rd & 32'h50, 32'h50);
        apb(1'b1, ADDR_BUF, 32'h3c);
        @(posedge ref_clk);
        chk(32'(sdaOen), 32'h0);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        apb(1'b0, ADDR_CFG, 32'h0);
        chk(rd, 32'h0);
        chk(32'({sclOen, sdaOen}), 32'h3);
        finalReport();
    end
endmodule
